/* File: rtl/sptp_defines.vh */
// sptp_defines.vh: constants for the supply-pulse trim programmer
// assumes a 20 MHz ref_clk; included by bare name from rtl files
`ifndef SPTP_DEFINES_VH
`define SPTP_DEFINES_VH
`define SPTP_CLK_MHZ 20
// supply level codes driven to the pulse amplifier
`define SPTP_LVL_OFF 2'h0
`define SPTP_LVL_HOLD 2'h1
`define SPTP_LVL_COUNT 2'h2
`define SPTP_LVL_STRIKE 2'h3
// times in microseconds, as printed
`define SPTP_OFF_GAP_US 20
`define SPTP_SHORT_PULSE_US 20
`define SPTP_FUSE_MIN_US 100
`define SPTP_FUSE_TYP_US 300
// cycle counts derived from times, the fuse count from its typical time
`define SPTP_OFF_GAP_CYC (`SPTP_OFF_GAP_US * `SPTP_CLK_MHZ)
`define SPTP_SHORT_CYC (`SPTP_SHORT_PULSE_US * `SPTP_CLK_MHZ)
`define SPTP_FUSE_CYC (`SPTP_FUSE_TYP_US * `SPTP_CLK_MHZ)
// addressing
`define SPTP_TRIM_BITS 5
`define SPTP_TRIM_MAX 6'h1f
`define SPTP_LOCK_ADDR 6'h20
`endif

/* File: rtl/sptp_timer.v */
// sptp_timer.v: down counter that pulses done after a loaded cycle count
// assumes load and count come from logic on ref_clk
`timescale 1ns/10ps
`include "sptp_defines.vh"
module sptp_timer (
	// clock and reset
	input wire ref_clk,
	input wire reset_n,
	// control
	input wire load,
	input wire [12:0] count,
	// status
	output wire busy,
	output wire done
);
	reg [12:0] cnt_reg;
	reg done_reg;
	// count down once loaded; done is one cycle when the count expires
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_reg <= 13'h0000;
			done_reg <= 1'b0;
		end else if (load) begin
			cnt_reg <= count;
			done_reg <= 1'b0;
		end else begin
			done_reg <= (cnt_reg == 13'h0001);
			if (cnt_reg != 13'h0000)
				cnt_reg <= cnt_reg - 13'h0001;
		end
	end
	assign busy = (cnt_reg != 13'h0000);
	assign done = done_reg;
endmodule

/* File: rtl/sptp_programmer.v */
// sptp_programmer.v: host that drives coded supply pulses into a two-wire switch
// assumes an external amplifier turns supply_level into the supply pin voltage
`timescale 1ns/10ps
`include "sptp_defines.vh"
module sptp_programmer (
	// clock and reset
	input wire ref_clk,
	input wire reset_n,
	// user command
	input wire cmd_start,
	input wire cmd_permanent,
	input wire cmd_lock,
	input wire [4:0] cmd_value,
	output wire cmd_ready,
	output wire cmd_done,
	// supply drive
	output wire [1:0] supply_level
);
	localparam ST_IDLE = 3'd0;
	localparam ST_PICK = 3'd1;
	localparam ST_KEY = 3'd2;
	localparam ST_ADDR = 3'd3;
	localparam ST_SEP = 3'd4;
	localparam ST_FUSE = 3'd5;
	localparam ST_GAP = 3'd6;
	localparam ST_END = 3'd7;
	localparam integer SHORT_INT = `SPTP_SHORT_CYC;
	localparam integer FUSE_INT = `SPTP_FUSE_CYC;
	localparam integer GAP_INT = `SPTP_OFF_GAP_CYC;
	// counts fit the 13-bit timer; the slices only drop zero high bits
	localparam [12:0] SHORT_CNT = SHORT_INT[12:0];
	localparam [12:0] FUSE_CNT = FUSE_INT[12:0];
	localparam [12:0] GAP_CNT = GAP_INT[12:0];

	reg [2:0] state_reg, state_next;
	reg [1:0] level_reg, level_next;
	reg [4:0] bits_reg, bits_next;
	reg [5:0] target_reg, target_next;
	reg [5:0] sent_reg, sent_next;
	reg [2:0] phase_reg, phase_next;
	reg perm_reg, perm_next;
	reg lock_reg, lock_next;
	reg done_reg, done_next;
	reg tload;
	reg [12:0] tcount;
	wire tbusy;
	wire tdone;

	sptp_timer u_timer (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.load(tload),
		.count(tcount),
		.busy(tbusy),
		.done(tdone)
	);

	// address of the lowest set bit of the pending permanent bits, its index plus one
	function [5:0] low_addr;
		input [4:0] b;
		integer i;
		begin
			low_addr = 6'h00;
			for (i = `SPTP_TRIM_BITS - 1; i >= 0; i = i - 1)
				if (b[i])
					low_addr = i[5:0] + 6'h01;
		end
	endfunction

	// state registers
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= ST_IDLE;
			level_reg <= `SPTP_LVL_OFF;
			bits_reg <= 5'h00;
			target_reg <= 6'h00;
			sent_reg <= 6'h00;
			phase_reg <= 3'h0;
			perm_reg <= 1'b0;
			lock_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			level_reg <= level_next;
			bits_reg <= bits_next;
			target_reg <= target_next;
			sent_reg <= sent_next;
			phase_reg <= phase_next;
			perm_reg <= perm_next;
			lock_reg <= lock_next;
			done_reg <= done_next;
		end
	end

	// sequencer: every pulse holds until the timer expires, then steps on
	always @* begin
		state_next = state_reg;
		level_next = level_reg;
		bits_next = bits_reg;
		target_next = target_reg;
		sent_next = sent_reg;
		phase_next = phase_reg;
		perm_next = perm_reg;
		lock_next = lock_reg;
		done_next = 1'b0;
		tload = 1'b0;
		tcount = SHORT_CNT;
		case (state_reg)
			ST_IDLE: begin
				if (cmd_start) begin
					perm_next = cmd_permanent | cmd_lock;
					lock_next = cmd_lock;
					bits_next = cmd_value;
					if (cmd_lock) begin
						target_next = `SPTP_LOCK_ADDR;
						state_next = ST_PICK;
					end else if (!cmd_permanent) begin
						// a trial value is counted out in one sequence
						target_next = {1'b0, cmd_value};
						state_next = ST_PICK;
					end else if (cmd_value == 5'h00) begin
						// zero bits are never fused, nothing to send
						done_next = 1'b1;
					end else begin
						state_next = ST_PICK;
					end
				end
			end
			ST_PICK: begin
				if (perm_reg && !lock_reg)
					target_next = low_addr(bits_reg);
				if (!perm_reg && target_reg == 6'h00) begin
					// trial zero: just hold so prior state stays cleared
					level_next = `SPTP_LVL_HOLD;
					done_next = 1'b1;
					state_next = ST_IDLE;
				end else begin
					// key opens with a short strike straight from the supply level
					level_next = `SPTP_LVL_STRIKE;
					phase_next = 3'h0;
					tload = 1'b1;
					state_next = ST_KEY;
				end
			end
			ST_KEY: begin
				if (tdone) begin
					tload = 1'b1;
					phase_next = phase_reg + 3'h1;
					case (phase_reg)
						3'h0: level_next = `SPTP_LVL_COUNT;
						3'h1: level_next = `SPTP_LVL_STRIKE;
						default: begin
							level_next = `SPTP_LVL_HOLD;
							sent_next = 6'h00;
							state_next = ST_ADDR;
						end
					endcase
				end
			end
			ST_ADDR: begin
				// alternate count pulse and hold gap, each one short time
				if (tdone) begin
					tload = 1'b1;
					if (level_reg == `SPTP_LVL_HOLD) begin
						if (sent_reg == target_reg) begin
							if (perm_reg) begin
								level_next = `SPTP_LVL_STRIKE;
								tcount = FUSE_CNT;
								state_next = ST_FUSE;
							end else begin
								state_next = ST_END;
							end
						end else begin
							level_next = `SPTP_LVL_COUNT;
							sent_next = sent_reg + 6'h01;
						end
					end else begin
						level_next = `SPTP_LVL_HOLD;
					end
				end
			end
			ST_FUSE: begin
				if (tdone) begin
					// drop to zero to clear the device before the next bit
					level_next = `SPTP_LVL_OFF;
					tcount = GAP_CNT;
					tload = 1'b1;
					state_next = ST_GAP;
				end
			end
			ST_GAP: begin
				if (tdone) begin
					if (!lock_reg)
						bits_next = bits_reg & ~(5'h01 << (target_reg[2:0] - 3'h1));
					state_next = ST_END;
				end
			end
			ST_END: begin
				if (perm_reg && !lock_reg && bits_next != 5'h00) begin
					state_next = ST_PICK;
				end else begin
					// provisional leaves the supply at hold to keep bits
					if (!perm_reg)
						level_next = `SPTP_LVL_HOLD;
					done_next = 1'b1;
					state_next = ST_IDLE;
				end
			end
			default: state_next = ST_IDLE;
		endcase
	end

	assign cmd_ready = (state_reg == ST_IDLE) && !tbusy;
	assign cmd_done = done_reg;
	assign supply_level = level_reg;
endmodule

/* File: test/sptp_programmer_asserts.sv */
// sptp_programmer_asserts.sv: timing checks on the supply drive
// assumes a bind onto sptp_programmer and a 20 MHz ref_clk
`timescale 1ns/10ps
module sptp_checker (
	// clock and reset
	input wire ref_clk,
	input wire reset_n,
	// user side
	input wire cmd_start,
	input wire cmd_permanent,
	input wire cmd_lock,
	input wire [4:0] cmd_value,
	input wire cmd_ready,
	input wire cmd_done,
	// supply drive
	input wire [1:0] supply_level
);
	reg [1:0] lvl_reg;
	reg [12:0] run_reg;
	wire chg = supply_level != lvl_reg;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	// length of the level now ending, minus one; saturates so long idles stay valid
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			lvl_reg <= 2'h0;
			run_reg <= 13'h0;
		end else begin
			lvl_reg <= supply_level;
			run_reg <= chg ? 13'h0 : run_reg + {12'h0, run_reg != 13'h1fff};
		end
	end
	chk_pulse_min: assert property (chg && lvl_reg != 2'h0 |-> run_reg >= 13'h18f)
		else $error("level held too briefly");
	// timer reload costs one cycle, so each timed level except the off gap stands count plus one
	chk_strike_len: assert property (chg && lvl_reg == 2'h3 |-> run_reg == 13'h190 || run_reg == 13'h1770)
		else $error("strike length wrong");
	chk_count_len: assert property (chg && lvl_reg == 2'h2 |-> run_reg == 13'h190)
		else $error("count pulse length wrong");
	chk_fuse_off: assert property (chg && lvl_reg == 2'h3 && run_reg == 13'h1770 |-> supply_level == 2'h0)
		else $error("no off after fuse strike");
	chk_count_next: assert property (chg && lvl_reg == 2'h2 |-> supply_level != 2'h0)
		else $error("count pulse dropped to off");
	chk_off_next: assert property (chg && lvl_reg == 2'h0 |-> supply_level == 2'h3)
		else $error("sequence not opened by strike");
	chk_take_strike: assert property (cmd_start && cmd_ready && (cmd_lock || cmd_value != 5'h00) |-> ##2 (supply_level == 2'h3) [*8])
		else $error("key strike missing after take");
	chk_idle_stable: assert property (cmd_ready && !cmd_start |=> $stable(supply_level))
		else $error("supply moved while idle");
endmodule

/* File: test/sptp_device_model.sv */
// sptp_device_model.sv: behavioural switch decoding coded supply levels
// assumes supply_level changes only on ref_clk edges
`timescale 1ns/10ps
module sptp_device_model (
	// clock and supply
	input wire ref_clk,
	input wire [1:0] supply_level,
	// observed state
	output wire [4:0] trim_code,
	output reg [4:0] fused,
	output reg locked,
	output integer bad_pulses
);
	reg [1:0] last = 2'h0;
	reg [4:0] prov = 5'h00;
	integer run = 0;
	integer stage = 0;
	integer addr = 0;
	initial fused = 5'h00;
	initial locked = 1'b0;
	initial bad_pulses = 0;
	// five bitfields; unset ones read zero, blown ones stay one
	assign trim_code = fused | prov;
	// decode each level as it ends, so its length is known
	always @(posedge ref_clk) begin
		if (supply_level == last) begin
			run = run + 1;
		end else begin
			if (last != 2'h0 && run < 400)
				bad_pulses = bad_pulses + 1;
			case (last)
			2'h0: begin
				prov = 5'h00;
				stage = 0;
				addr = 0;
			end
			2'h2: if (locked)
				stage = 0;
			else if (stage == 1)
				stage = 2;
			else if (stage == 3) begin
				addr = addr + 1;
				prov = addr[4:0];
			end else
				stage = 0;
			2'h3: if (run >= 2000 && stage == 3 && !locked) begin
				if (addr == 32)
					locked = 1'b1;
				else if (addr >= 1 && addr <= 5)
					fused[addr - 1] = 1'b1;
				stage = 0;
				addr = 0;
			end else if (stage == 2 && !locked)
				stage = 3;
			else begin
				stage = locked ? 0 : 1;
				addr = 0;
			end
			default: ;
			endcase
			run = 1;
			last = supply_level;
			// registers clear as soon as the supply reaches zero, and again when it returns
			if (supply_level == 2'h0) begin
				prov = 5'h00;
				stage = 0;
				addr = 0;
			end
		end
	end
endmodule

/* File: test/sptp_programmer_tb.sv */
// sptp_programmer_tb.sv: command-level bench against a decoding device model
// assumes rtl/ design files and the test/ model and checker
`timescale 1ns/10ps
module sptp_programmer_tb;
	reg ref_clk = 1'b0;
	reg reset_n = 1'b0;
	reg cmd_start = 1'b0;
	reg cmd_permanent = 1'b0;
	reg cmd_lock = 1'b0;
	reg [4:0] cmd_value = 5'h00;
	wire cmd_ready;
	wire cmd_done;
	wire [1:0] supply_level;
	wire [4:0] trim_code;
	wire [4:0] fused;
	wire locked;
	integer bad_pulses;
	integer failures = 0;
	integer n_tests = 0;
	// 20 MHz reference
	always #25 ref_clk = ~ref_clk;
	sptp_programmer u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .cmd_start(cmd_start),
		.cmd_permanent(cmd_permanent), .cmd_lock(cmd_lock), .cmd_value(cmd_value),
		.cmd_ready(cmd_ready), .cmd_done(cmd_done), .supply_level(supply_level));
	sptp_device_model u_dev (.ref_clk(ref_clk), .supply_level(supply_level),
		.trim_code(trim_code), .fused(fused), .locked(locked), .bad_pulses(bad_pulses));
	task check(input string name, input [4:0] seen, input [4:0] exp);
		n_tests = n_tests + 1;
		if (seen !== exp) begin
			failures = failures + 1;
			$display("CHECK FAILED %0s expected %h seen %h", name, exp, seen);
		end
	endtask
	task complete_run;
		if (failures == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// one command; poke fires a start mid-run that must be ignored
	task run_cmd(input p, input l, input [4:0] v, input poke);
		integer n;
		n = 0;
		// a trial leaves the hold timer running, so ready may lag done by a level
		while (cmd_ready !== 1'b1 && n < 1000) begin
			@(posedge ref_clk);
			#2;
			n = n + 1;
		end
		check("ready seen", {4'h0, cmd_ready}, 5'h01);
		cmd_start = 1'b1;
		cmd_permanent = p;
		cmd_lock = l;
		cmd_value = v;
		@(posedge ref_clk);
		#2;
		cmd_start = 1'b0;
		n = 0;
		while (cmd_done !== 1'b1 && n < 40000) begin
			cmd_start = poke && n == 1000;
			cmd_value = (poke && n == 1000) ? 5'h09 : v;
			@(posedge ref_clk);
			#2;
			n = n + 1;
		end
		check("done seen", {4'h0, cmd_done}, 5'h01);
	endtask
	initial begin
		repeat (10) @(posedge ref_clk);
		#2;
		check("reset level", {3'h0, supply_level}, 5'h00);
		reset_n = 1'b1;
		run_cmd(1'b0, 1'b0, 5'h02, 1'b1);
		check("trial 2", trim_code, 5'h02);
		check("hold kept", {3'h0, supply_level}, 5'h01);
		run_cmd(1'b0, 1'b0, 5'h1f, 1'b0);
		check("trial 31", trim_code, 5'h1f);
		run_cmd(1'b1, 1'b0, 5'h05, 1'b0);
		check("fused 5", fused, 5'h05);
		check("cleared", trim_code, 5'h05);
		check("off after", {3'h0, supply_level}, 5'h00);
		run_cmd(1'b0, 1'b1, 5'h00, 1'b0);
		check("lock", {4'h0, locked}, 5'h01);
		run_cmd(1'b0, 1'b0, 5'h01, 1'b0);
		check("locked trial", trim_code, 5'h05);
		check("widths", bad_pulses[4:0], 5'h00);
		complete_run;
	end
	// whole run needs about 86000 cycles
	initial begin
		repeat (95000) @(posedge ref_clk);
		failures = failures + 1;
		complete_run;
	end
endmodule
bind sptp_programmer sptp_checker u_chk (.ref_clk(ref_clk), .reset_n(reset_n),
	.cmd_start(cmd_start), .cmd_permanent(cmd_permanent), .cmd_lock(cmd_lock),
	.cmd_value(cmd_value), .cmd_ready(cmd_ready), .cmd_done(cmd_done),
	.supply_level(supply_level));
